// File: hdl/bsc_pkg.sv
// Purpose: Shared constants for the burst static RAM controller.
// Assumes: APB register access, one 200 MHz clock, synchronous active-low reset.
// Notes: Size codes and register map are used by the controller and the bench.
//
// Summary of operation
// RULE1: RAM select only when address 31..20 zero, start strobe and map qualifier.
// RULE2: Other-space select on start strobe when outside RAM range or map negated.
// RULE3: RAM select acts on state only after being sampled at a clock edge.
// RULE4: Burst state stays 0 unless burst; steps 0-1-2-3-0 on each acknowledge.
// RULE5: Two state bits, Gray coded: 00, a only, both, b only.
// RULE6: Reset clears state bits; bit b holds until acknowledge in state 3.
// RULE7: Only a line size code makes a transfer a burst.
// RULE8: Burst indication set in state 0 on line size, held select, phase low.
// RULE9: Held RAM select set by sampled select, kept while burst persists.
// RULE10: Initial access enables even buffers for address bit 2 low, odd otherwise.
// RULE11: Burst states alternate buffers by state and bit 2; state 0 holds enable.
// RULE12: Even buffers serve banks 0 and 2, odd buffers banks 1 and 3.
// RULE13: Selected bank equals long-word address bits 3 and 2.
// RULE14: Every read drives a full long word from the selected bank.
// RULE15: Master ignores unrequested read bytes; cacheable reads take full words.
// RULE16: Write strobe held through a write; sixteen byte enables do the writing.
// RULE17: Write byte enables reach the RAM only while write gate active.
// RULE18: In state 0 byte enables start from bank, size and low address bits.
// RULE19: A byte enable holds until acknowledge, then releases.
// RULE20: On burst acknowledge the next bank in wrap order is enabled.
// RULE21: Reset forces all registered byte enables inactive.
// RULE22: One combined acknowledge from held select or external acknowledge.
// RULE23: All registered outputs update on the rising edge of the one clock.
package bsc_pkg;
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] OFS_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] OFS_STATUS = 12'h004;
    localparam logic [APB_AW-1:0] OFS_XFER_COUNT = 12'h008;

    localparam int CTRL_RAM_EN_BIT = 0;
    localparam logic CTRL_RAM_EN_RST = 1'b1;

    localparam int ST_BIT_A = 0;
    localparam int ST_BIT_B = 1;
    localparam int ST_HELD = 2;
    localparam int ST_BURST = 3;
    localparam int ST_EVEN = 4;
    localparam int ST_ODD = 5;
    localparam int ST_WGATE = 6;
    localparam int ST_RDEN_LO = 8;
    localparam int ST_BE_LO = 16;

    // Size code {high, low}
    localparam logic [1:0] SIZE_LONG = 2'b00;
    localparam logic [1:0] SIZE_BYTE = 2'b01;
    localparam logic [1:0] SIZE_WORD = 2'b10;
    localparam logic [1:0] SIZE_LINE = 2'b11;

    // Burst state {b, a}, Gray coded
    localparam logic [1:0] BST_0 = 2'b00;
    localparam logic [1:0] BST_1 = 2'b01;
    localparam logic [1:0] BST_2 = 2'b11;
    localparam logic [1:0] BST_3 = 2'b10;

    localparam int RAM_DECODE_HI = 31;
    localparam int RAM_DECODE_LO = 20;
    localparam int NUM_BANKS = 4;
    localparam int LANES_PER_BANK = 4;
    localparam int NUM_BYTE_EN = NUM_BANKS * LANES_PER_BANK;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// File: hdl/bsc_burst_sram_ctrl.sv
// Purpose: Glue for a 128-bit four-bank static RAM with 2-1-1-1 line bursts.
// Assumes: Processor bus signals are synchronous to sys_clk; all pins active high except rst_b, and bufferedReadWrite, which is low for a write.
// Notes: Every output is registered, so pin timing trails the decode by one clock.
`timescale 1ns/10ps
module bsc_burst_sram_ctrl #(
    parameter int COUNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [31:0] busAddress,
    input wire logic transferStartStrobe,
    input wire logic mapQualifier,
    input wire logic sizeCodeHigh,
    input wire logic sizeCodeLow,
    input wire logic bufferedReadWrite,
    input wire logic busClockPhase,
    input wire logic externalAckIn,
    output logic ramSelect_q,
    output logic otherSpaceSelect_q,
    output logic transferAck_q,
    output logic stateBitA_q,
    output logic stateBitB_q,
    output logic heldSramSelect_q,
    output logic burstActive_q,
    output logic evenBufferEnable_q,
    output logic oddBufferEnable_q,
    output logic writeEnableGate_q,
    output logic ramWriteStrobe_q,
    output logic [bsc_pkg::NUM_BANKS-1:0] laneReadEnable_q,
    output logic [bsc_pkg::NUM_BYTE_EN-1:0] byteWriteEnable_q,
    output logic [bsc_pkg::NUM_BYTE_EN-1:0] ramByteEnable_q,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bsc_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q
);
    import bsc_pkg::*;

    if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count_w
        $error("COUNT_W must lie between 1 and 32");
    end

    logic ramEnable_q;
    logic burstHold_q;
    logic [COUNT_W-1:0] xferCount_q;

    // Address decode, combinational and glitch prone
    logic inRamRange;
    logic ramSel;
    logic otherSel;
    assign inRamRange = ~|busAddress[RAM_DECODE_HI:RAM_DECODE_LO];
    assign ramSel = inRamRange & transferStartStrobe & mapQualifier & ramEnable_q; // RULE1
    // Decode enable only gates the RAM side; the other space keeps its own map
    assign otherSel = transferStartStrobe & ((mapQualifier & ~inRamRange)
                      | ~mapQualifier); // RULE2

    logic [1:0] sizeCode;
    logic [1:0] lwAddr;
    logic [1:0] stateCode;
    logic [1:0] stateIdx;
    logic [1:0] curBank;
    logic [1:0] nextBank;
    logic inS0;
    logic inS1;
    logic inS2;
    logic inS3;
    logic ack;
    logic isWrite;
    assign sizeCode = {sizeCodeHigh, sizeCodeLow};
    assign lwAddr = busAddress[3:2]; // RULE13
    assign stateCode = {stateBitB_q, stateBitA_q};
    assign inS0 = stateCode == BST_0;
    assign inS1 = stateCode == BST_1;
    assign inS2 = stateCode == BST_2;
    assign inS3 = stateCode == BST_3;
    assign ack = transferAck_q;
    assign isWrite = ~bufferedReadWrite;

    always_comb begin
        unique case (stateCode)
            BST_0: stateIdx = 2'd0;
            BST_1: stateIdx = 2'd1;
            BST_2: stateIdx = 2'd2;
            BST_3: stateIdx = 2'd3;
        endcase
    end
    // Bank being transferred now, and the one after it in wrap order
    assign curBank = lwAddr + stateIdx;
    assign nextBank = lwAddr + stateIdx + 2'd1;

    // Burst indication; the hold flop breaks the feedback loop of the equation
    logic burst;
    assign burst = (sizeCode == SIZE_LINE && heldSramSelect_q && inS0 && !busClockPhase) // RULE7 RULE8
                   || (burstHold_q && !inS3 && heldSramSelect_q); // RULE8

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            burstHold_q <= 1'b0;
            burstActive_q <= 1'b0;
        end else begin
            burstHold_q <= burst;
            burstActive_q <= burst;
        end
    end

    // Held select only ever sees the sampled select
    logic heldSel_d;
    assign heldSel_d = ramSel | (heldSramSelect_q & burst); // RULE3 RULE9

    always_ff @(posedge sys_clk) begin // RULE23
        if (!rst_b) begin
            heldSramSelect_q <= 1'b0;
            ramSelect_q <= 1'b0;
            otherSpaceSelect_q <= 1'b0;
        end else begin
            heldSramSelect_q <= heldSel_d; // RULE9
            ramSelect_q <= ramSel;
            otherSpaceSelect_q <= otherSel;
        end
    end

    // Ack leaves with the held select it is built from
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            transferAck_q <= 1'b0;
        end else begin
            transferAck_q <= heldSel_d | externalAckIn; // RULE22
        end
    end

    // Gray burst counter
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            stateBitA_q <= 1'b0; // RULE6
            stateBitB_q <= 1'b0; // RULE6
        end else begin
            stateBitA_q <= ((inS0 | inS1) & ack & burst) | (stateBitA_q & ~(inS2 & ack)); // RULE4 RULE5
            stateBitB_q <= (stateBitA_q & ack) | (stateBitB_q & ~(inS3 & ack)); // RULE5 RULE6
        end
    end

    // Data buffer enables; even side carries banks 0 and 2
    logic evenEn_d;
    logic oddEn_d;
    always_comb begin
        if (inS0) begin
            evenEn_d = (ramSel & ~lwAddr[0]) | (evenBufferEnable_q & heldSramSelect_q); // RULE10 RULE11
            oddEn_d = (ramSel & lwAddr[0]) | (oddBufferEnable_q & heldSramSelect_q); // RULE10 RULE11
        end else begin
            evenEn_d = heldSramSelect_q & ~curBank[0]; // RULE11 RULE12
            oddEn_d = heldSramSelect_q & curBank[0]; // RULE11 RULE12
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            evenBufferEnable_q <= 1'b0;
            oddBufferEnable_q <= 1'b0;
        end else begin
            evenBufferEnable_q <= evenEn_d;
            oddBufferEnable_q <= oddEn_d;
        end
    end

    // Write gate and RAM write strobe
    logic wGate_d;
    assign wGate_d = isWrite & heldSel_d; // RULE17

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            writeEnableGate_q <= 1'b0;
            ramWriteStrobe_q <= 1'b0;
        end else begin
            writeEnableGate_q <= wGate_d;
            ramWriteStrobe_q <= isWrite & (ramSel | heldSel_d); // RULE16
        end
    end

    // Read enables: whole long word per bank; one bank in state 0, current and next bank in burst states; size ignored
    logic [NUM_BANKS-1:0] rdEn_d;
    logic [NUM_BYTE_EN-1:0] be_d;

    genvar gb;
    genvar gl;
    generate
        for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
            always_comb begin
                if (inS0) begin
                    rdEn_d[gb] = ~isWrite & ((ramSel & (lwAddr == 2'(gb)))
                                 | (laneReadEnable_q[gb] & heldSramSelect_q)); // RULE13 RULE14
                end else begin
                    rdEn_d[gb] = ~isWrite & heldSramSelect_q
                                 & ((curBank == 2'(gb)) | (nextBank == 2'(gb))); // RULE14
                end
            end

            for (gl = 0; gl < LANES_PER_BANK; gl++) begin : g_lane
                localparam int IDX = gb * LANES_PER_BANK + gl;
                logic sizeHit;
                logic startHit;
                logic wrapHit;
                always_comb begin
                    unique case (sizeCode)
                        SIZE_BYTE: sizeHit = busAddress[1:0] == 2'(gl);
                        SIZE_WORD: sizeHit = busAddress[1] == 1'(gl / 2);
                        SIZE_LONG: sizeHit = 1'b1;
                        SIZE_LINE: sizeHit = 1'b1;
                    endcase
                end
                assign startHit = inS0 & ramSel & (lwAddr == 2'(gb)) & sizeHit; // RULE18
                // Next bank in wrap order comes up as the current one is acknowledged
                assign wrapHit = ack & burst & ~inS3 & (nextBank == 2'(gb)); // RULE20
                assign be_d[IDX] = rst_b & (startHit | (byteWriteEnable_q[IDX] & ~ack) | wrapHit); // RULE19
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            byteWriteEnable_q <= '0; // RULE21
            laneReadEnable_q <= '0;
            ramByteEnable_q <= '0;
        end else begin
            byteWriteEnable_q <= be_d; // RULE16
            laneReadEnable_q <= rdEn_d;
            for (int b = 0; b < NUM_BANKS; b++) begin
                // Write enables own the RAM lines only under the gate
                ramByteEnable_q[b*LANES_PER_BANK +: LANES_PER_BANK] <=
                    wGate_d ? be_d[b*LANES_PER_BANK +: LANES_PER_BANK] : {LANES_PER_BANK{rdEn_d[b]}}; // RULE17
            end
        end
    end

    // Completed RAM transfers, counted when the held select drops, once per single transfer or burst
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            xferCount_q <= '0;
        end else if (psel && penable && pready_q && pwrite && paddr == OFS_XFER_COUNT) begin
            xferCount_q <= '0;
        end else if (heldSramSelect_q && !heldSel_d) begin
            xferCount_q <= xferCount_q + COUNT_W'(1);
        end
    end

    // APB slave: one wait state, error on unmapped offsets
    logic apbAccess;
    logic addrMapped;
    logic [31:0] statusWord;
    assign apbAccess = psel & penable;
    assign addrMapped = (paddr == OFS_CTRL) | (paddr == OFS_STATUS) | (paddr == OFS_XFER_COUNT);

    always_comb begin
        statusWord = '0;
        statusWord[ST_BIT_A] = stateBitA_q;
        statusWord[ST_BIT_B] = stateBitB_q;
        statusWord[ST_HELD] = heldSramSelect_q;
        statusWord[ST_BURST] = burstActive_q;
        statusWord[ST_EVEN] = evenBufferEnable_q;
        statusWord[ST_ODD] = oddBufferEnable_q;
        statusWord[ST_WGATE] = writeEnableGate_q;
        statusWord[ST_RDEN_LO +: NUM_BANKS] = laneReadEnable_q;
        statusWord[ST_BE_LO +: NUM_BYTE_EN] = byteWriteEnable_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= apbAccess & ~pready_q;
            pslverr_q <= apbAccess & ~pready_q & ~addrMapped;
            if (apbAccess && !pready_q && !pwrite) begin
                if (paddr == OFS_CTRL) begin
                    prdata_q <= {31'h0000_0000, ramEnable_q};
                end else if (paddr == OFS_STATUS) begin
                    prdata_q <= statusWord;
                end else if (paddr == OFS_XFER_COUNT) begin
                    prdata_q <= 32'(xferCount_q);
                end else begin
                    prdata_q <= UNMAPPED_READ;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ramEnable_q <= CTRL_RAM_EN_RST;
        end else if (apbAccess && pready_q && pwrite && paddr == OFS_CTRL) begin
            ramEnable_q <= pwdata[CTRL_RAM_EN_BIT];
        end
    end
endmodule

// File: dv/bsc_burst_sram_ctrl_checker.sv
// Purpose: Pin-level checks on the burst static RAM controller.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to the controller, sees its ports only.
`timescale 1ns/10ps
module bsc_burst_sram_ctrl_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [31:0] busAddress,
    input wire logic transferStartStrobe,
    input wire logic mapQualifier,
    input wire logic bufferedReadWrite,
    input wire logic externalAckIn,
    input wire logic ramSelect_q,
    input wire logic otherSpaceSelect_q,
    input wire logic transferAck_q,
    input wire logic stateBitA_q,
    input wire logic stateBitB_q,
    input wire logic heldSramSelect_q,
    input wire logic evenBufferEnable_q,
    input wire logic oddBufferEnable_q,
    input wire logic writeEnableGate_q,
    input wire logic [15:0] byteWriteEnable_q,
    input wire logic burstActive_q,
    input wire logic ramWriteStrobe_q,
    input wire logic [15:0] ramByteEnable_q
);
    wire [1:0] st = {stateBitB_q, stateBitA_q};
    wire inRam = (busAddress[31:20] == 12'h000);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    AST_RAMSEL: assert property (ramSelect_q |-> $past(transferStartStrobe && mapQualifier && inRam))
        else $error("ram select without in-range strobe");
    AST_OTHER_SET: assert property ($past(transferStartStrobe && !mapQualifier) |-> otherSpaceSelect_q)
        else $error("unmapped strobe gave no other select");
    AST_OTHER_ONLY: assert property (otherSpaceSelect_q |-> $past(transferStartStrobe && !(mapQualifier && inRam)))
        else $error("other select without cause");
    AST_ACK: assert property ($past(rst_b) |-> transferAck_q == (heldSramSelect_q || $past(externalAckIn)))
        else $error("combined ack mismatch");
    AST_GRAY: assert property ($past(rst_b) && st != $past(st) |-> $past(transferAck_q) && st == {$past(st[0]), !$past(st[1])})
        else $error("illegal burst state step");
    AST_BHOLD: assert property ($past(rst_b) && $fell(stateBitB_q) |-> $past(!stateBitA_q && transferAck_q))
        else $error("state bit b dropped early");
    AST_RESET: assert property (disable iff (1'b0) !rst_b |=> st == 2'b00 && byteWriteEnable_q == 16'h0000)
        else $error("reset left state or byte enables set");
    AST_BWE_HOLD: assert property ($past(rst_b) && |($past(byteWriteEnable_q) & ~byteWriteEnable_q) |-> $past(transferAck_q))
        else $error("byte enable released without ack");
    AST_HELD_START: assert property ($rose(heldSramSelect_q) |-> ramSelect_q && oddBufferEnable_q == $past(busAddress[2]))
        else $error("held select start or buffer choice wrong");
    AST_BUF_EXCL: assert property (!(evenBufferEnable_q && oddBufferEnable_q))
        else $error("both buffer sets enabled");
    AST_WGATE: assert property (writeEnableGate_q |-> !$past(bufferedReadWrite))
        else $error("write gate during read");
    AST_RBE_GATE: assert property (writeEnableGate_q |-> ramByteEnable_q == byteWriteEnable_q)
        else $error("ram enables not from byte enables under write gate");
    AST_WSTROBE: assert property (writeEnableGate_q |-> ramWriteStrobe_q)
        else $error("write strobe low during gated write");
    AST_BURST_IND: assert property ($rose(stateBitA_q) |-> burstActive_q)
        else $error("burst state left 0 without burst indication");
    COV_BURST: cover property ($rose(stateBitB_q));
    COV_OTHER: cover property ($rose(otherSpaceSelect_q));
    COV_WGATE: cover property ($rose(writeEnableGate_q));
endmodule
bind bsc_burst_sram_ctrl bsc_burst_sram_ctrl_checker uChk (.sys_clk, .rst_b, .busAddress, .transferStartStrobe,
    .mapQualifier, .bufferedReadWrite, .externalAckIn, .ramSelect_q, .otherSpaceSelect_q, .transferAck_q,
    .stateBitA_q, .stateBitB_q, .heldSramSelect_q, .evenBufferEnable_q, .oddBufferEnable_q,
    .writeEnableGate_q, .byteWriteEnable_q, .burstActive_q, .ramWriteStrobe_q, .ramByteEnable_q);

// File: dv/bsc_cpu_model.sv
// Purpose: Processor bus master issuing single and line transfers.
// Assumes: Address and size held until the last ack.
// Notes: Snapshots the first response cycle, gathers enables seen.
`timescale 1ns/10ps
module bsc_cpu_model
    import bsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic transferAck_q,
    input wire logic ramSelect_q,
    input wire logic otherSpaceSelect_q,
    input wire logic oddBufferEnable_q,
    input wire logic [bsc_pkg::NUM_BANKS-1:0] laneReadEnable_q,
    input wire logic [bsc_pkg::NUM_BYTE_EN-1:0] byteWriteEnable_q,
    output logic [31:0] busAddress,
    output logic transferStartStrobe,
    output logic mapQualifier,
    output logic [1:0] sizeCode,
    output logic bufferedReadWrite,
    output logic externalAckIn
);
    logic [2:0] snapSel;
    logic [15:0] snapBwe, bweSeen;
    logic [3:0] laneSeen;
    int ackCount;
    initial begin
        {busAddress, transferStartStrobe, mapQualifier, sizeCode, bufferedReadWrite, externalAckIn} = '0;
    end
    task automatic xfer(input logic [31:0] a, input logic m, input logic [1:0] sz, input logic rd, input logic ext);
        ackCount = 0;
        laneSeen = 4'h0;
        bweSeen = 16'h0000;
        @(posedge sys_clk);
        busAddress <= a;
        mapQualifier <= m;
        sizeCode <= sz;
        bufferedReadWrite <= rd;
        transferStartStrobe <= 1'b1;
        @(posedge sys_clk);
        transferStartStrobe <= 1'b0;
        externalAckIn <= ext;
        #1 snapSel = {ramSelect_q, otherSpaceSelect_q, oddBufferEnable_q};
        snapBwe = byteWriteEnable_q;
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk);
            externalAckIn <= 1'b0;
            if (transferAck_q === 1'b1) ackCount++;
            else if (ackCount > 0) break;
            laneSeen |= laneReadEnable_q;
            bweSeen |= byteWriteEnable_q;
        end
        // Released address lines keep changing
        busAddress <= ~a;
    endtask
endmodule

// File: dv/bsc_burst_sram_ctrl_tb.sv
// Purpose: Self-checking bench for the burst static RAM controller.
// Assumes: Bus clock phase held low, so bursts may always start.
// Notes: Table of single transfers, then bursts, registers, mid-run reset.
`timescale 1ns/10ps
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin numErrors++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module bsc_burst_sram_ctrl_tb;
    import bsc_pkg::*;
    typedef struct packed {logic [31:0] a; logic m; logic [1:0] sz; logic rd; logic ext;
        logic [2:0] sel; logic [3:0] lane; logic [15:0] bwe;} bsc_row_s;
    // Fields: address, map, size, read, other ack | ram/other/odd, lanes, byte enables
    bsc_row_s rows [7] = '{
        '{32'h0000_0004, 1'b1, SIZE_LONG, 1'b1, 1'b0, 3'b101, 4'h2, 16'h00f0},
        '{32'h0000_000e, 1'b1, SIZE_BYTE, 1'b1, 1'b0, 3'b101, 4'h8, 16'h4000},
        '{32'h0000_0009, 1'b1, SIZE_BYTE, 1'b0, 1'b0, 3'b100, 4'h0, 16'h0200},
        '{32'h0000_0002, 1'b1, SIZE_WORD, 1'b0, 1'b0, 3'b100, 4'h0, 16'h000c},
        '{32'h0000_0004, 1'b1, SIZE_LONG, 1'b0, 1'b0, 3'b101, 4'h0, 16'h00f0},
        '{32'h0010_0000, 1'b1, SIZE_LONG, 1'b1, 1'b1, 3'b010, 4'h0, 16'h0000},
        '{32'h0000_0000, 1'b0, SIZE_LONG, 1'b1, 1'b1, 3'b010, 4'h0, 16'h0000}};
    logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, busClockPhase = 0;
    logic transferStartStrobe, mapQualifier, bufferedReadWrite, externalAckIn, ramSelect_q, otherSpaceSelect_q;
    logic transferAck_q, stateBitA_q, stateBitB_q, heldSramSelect_q, burstActive_q, evenBufferEnable_q;
    logic oddBufferEnable_q, writeEnableGate_q, ramWriteStrobe_q, pready_q, pslverr_q, err;
    logic [1:0] sizeCode;
    logic [3:0] laneReadEnable_q;
    logic [15:0] byteWriteEnable_q, ramByteEnable_q;
    logic [11:0] paddr = 12'h000;
    logic [31:0] busAddress, pwdata = 32'h0, prdata_q, rdat;
    int numErrors = 0, numChecks = 0;
    always #2.5 sys_clk = ~sys_clk;
    bsc_burst_sram_ctrl DUT (.sys_clk, .rst_b, .busAddress, .transferStartStrobe, .mapQualifier,
        .sizeCodeHigh(sizeCode[1]), .sizeCodeLow(sizeCode[0]), .bufferedReadWrite, .busClockPhase, .externalAckIn,
        .ramSelect_q, .otherSpaceSelect_q, .transferAck_q, .stateBitA_q, .stateBitB_q, .heldSramSelect_q,
        .burstActive_q, .evenBufferEnable_q, .oddBufferEnable_q, .writeEnableGate_q, .ramWriteStrobe_q,
        .laneReadEnable_q, .byteWriteEnable_q, .ramByteEnable_q, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata_q, .pready_q, .pslverr_q);
    bsc_cpu_model proc (.sys_clk, .transferAck_q, .ramSelect_q, .otherSpaceSelect_q, .oddBufferEnable_q,
        .laneReadEnable_q, .byteWriteEnable_q, .busAddress, .transferStartStrobe, .mapQualifier, .sizeCode,
        .bufferedReadWrite, .externalAckIn);
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge sys_clk);
        end while (pready_q !== 1'b1);
        rdat = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        numErrors++;
        completeRun();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1 `CHK("idle", 18'h0, {transferAck_q, heldSramSelect_q, byteWriteEnable_q})
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl", {31'h0, CTRL_RAM_EN_RST, 1'b0}, {rdat, err})
        apb(1'b1, OFS_XFER_COUNT, 32'h0);
        foreach (rows[i]) begin
            proc.xfer(rows[i].a, rows[i].m, rows[i].sz, rows[i].rd, rows[i].ext);
            `CHK("sel", rows[i].sel, proc.snapSel)
            `CHK("bwe", rows[i].bwe, proc.snapBwe)
            `CHK("lanes", rows[i].lane, proc.laneSeen)
            `CHK("acks", 1, proc.ackCount)
        end
        apb(1'b0, OFS_XFER_COUNT, 32'h0);
        `CHK("count", 32'h5, rdat)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("unmapped", 33'h1, {rdat, err})
        proc.xfer(32'h0000_0004, 1'b1, SIZE_LINE, 1'b1, 1'b0);
        `CHK("burst acks", 4, proc.ackCount)
        `CHK("burst lanes", 4'hf, proc.laneSeen)
        proc.xfer(32'h0000_000c, 1'b1, SIZE_LINE, 1'b0, 1'b0);
        `CHK("burst bwe", 16'hffff, proc.bweSeen)
        `CHK("state", 2'b00, {stateBitB_q, stateBitA_q})
        apb(1'b1, OFS_CTRL, 32'h0);
        proc.xfer(32'h0000_0004, 1'b1, SIZE_LONG, 1'b1, 1'b0);
        `CHK("disabled", 1'b0, proc.snapSel[2])
        apb(1'b1, OFS_CTRL, 32'h1);
        fork
            proc.xfer(32'h0000_0008, 1'b1, SIZE_LINE, 1'b0, 1'b0);
        join_none
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 `CHK("reset state", 18'h0, {stateBitB_q, stateBitA_q, byteWriteEnable_q})
        @(posedge sys_clk);
        rst_b <= 1'b1;
        wait fork;
        completeRun();
    end
endmodule
